// ---- shared/dca_map.svh ----
// Constants for the DDR3 command and address input stage
`ifndef DCA_MAP_SVH
`define DCA_MAP_SVH

// Command code {cs_n, ras_n, cas_n, we_n}
`define DCA_CMD_MRS 4'h0
`define DCA_CMD_REF 4'h1
`define DCA_CMD_PRE 4'h2
`define DCA_CMD_ACT 4'h3
`define DCA_CMD_WR 4'h4
`define DCA_CMD_RD 4'h5
`define DCA_CMD_ZQ 4'h6
`define DCA_CMD_NOP 4'h7

// Address bit positions
`define DCA_AP_BIT 10
`define DCA_BC_BIT 12
`define DCA_TERMINATION_STROBE_BIT 11
// Mode register one: on-die termination field bits (nonzero means enabled)
`define DCA_RTT_B0 2
`define DCA_RTT_B1 6
`define DCA_RTT_B2 9

// Reset values and bank count
`define DCA_MR1_RST 16'h0000
`define DCA_NUM_BANKS 8

`endif

// ---- shared/dca_pkg.sv ----
// Types for the DDR3 command and address input stage
`default_nettype none
package dca_pkg;
	typedef enum logic [2:0] {
		DCA_C_NONE = 3'b000,
		DCA_C_ACT = 3'b001,
		DCA_C_RD = 3'b010,
		DCA_C_WR = 3'b011,
		DCA_C_PRE = 3'b100,
		DCA_C_MRS = 3'b101,
		DCA_C_OTHER = 3'b110
	} dca_cmd_t;

	typedef enum logic [1:0] {
		DCA_P_RUN = 2'b00,
		DCA_P_PRE_PD = 2'b01,
		DCA_P_ACT_PD = 2'b10
	} dca_pwr_t;
endpackage : dca_pkg
`default_nettype wire

// ---- design/dca_sync.sv ----
// Two-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
`default_nettype none
module dca_sync #(
	parameter int W = 1
) (
	input wire logic i_clk, // Destination clock
	input wire logic i_rst, // Asynchronous reset, active high
	input wire logic [W-1:0] i_d, // Level from the other domain
	output logic [W-1:0] o_q // Synchronised level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dca_sync_t;
	dca_sync_t st_reg;
	dca_sync_t st_next;

	// First stage is only read by the second
	always_comb begin
		st_next = st_reg;
		st_next.s1 = i_d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_q = st_reg.s2;
endmodule : dca_sync
`default_nettype wire

// ---- design/dca_cmd_addr_in.sv ----
// DDR3 command, address and control input stage
// How it works
// (R1) Control and address inputs are captured on the rising true-clock crossing.
// (R2) Output strobe timing is referenced to the differential clock crossings.
// (R3) Registered clock enable high enables internal circuitry; low disables it.
// (R4) Clock enable low enters precharge or active power-down per open rows.
// (R5) Power-down entry and exit come only from registered clock enable.
// (R6) In power-down, only clock, enable, reset and termination buffers stay on.
// (R7) Commands are ignored on edges where chip select is registered high.
// (R8) Commands decode from chip select, row, column strobes and write enable.
// (R9) Registered termination enable applies termination to data-side pins.
// (R10) Termination enable is ignored when mode register one disables termination.
// (R11) Write beats with mask sampled high are discarded.
// (R12) Write mask is sampled on both strobe edges, one per beat.
// (R13) Mode register one bit 11 picks mask or termination strobe on x8.
// (R14) On x16, lower mask covers bits 0-7, upper covers 8-15.
// (R15) Bank select chooses the target of activate, read, write, precharge.
// (R16) Bank select picks which of four mode registers is loaded.
// (R17) Address gives row on activate, column on read and write.
// (R18) Address inputs carry the mode register operation code.
// (R19) In x16 use the controller holds address bit 15 high.
// (R20) Bit 10 requests auto-precharge; on precharge it selects all banks.
// (R21) Bit 12 high gives burst of eight, low chops to four.
// (R22) Active-low reset pin resets the device whenever low.
// (R23) A masked cycle is a deselect; bank state stays unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "dca_map.svh"
module dca_cmd_addr_in #(
	parameter int AW = 16, // Address width
	parameter int BW = 3, // Bank select width
	parameter bit X16 = 1'b0 // Part is wired as x16
) (
	input wire logic i_sys_clk, // Core clock
	input wire logic i_rst, // Core reset, active high
	input wire logic i_diff_clock, // Link clock, true phase of the pair
	input wire logic i_reset_n, // Device reset pin, active low
	input wire logic i_clk_en, // Clock enable pin
	input wire logic i_cs_n, // Chip select, active low
	input wire logic i_ras_n, // Row strobe, active low
	input wire logic i_cas_n, // Column strobe, active low
	input wire logic i_we_n, // Write enable, active low
	input wire logic [BW-1:0] i_bank_select, // Bank select pins
	input wire logic [AW-1:0] i_addr, // Address pins
	input wire logic i_termination_enable, // Termination enable pin
	input wire logic i_strobe, // Write data strobe as a level
	input wire logic [15:0] i_wdata, // Write data pins
	input wire logic i_write_data_mask, // Mask pin; lower byte mask on x16
	input wire logic i_upper_byte_mask, // Upper byte mask pin, x16 only
	output logic o_cmd_valid, // Decoded command pulse, core domain
	output logic [2:0] o_cmd, // Decoded command kind
	output logic [BW-1:0] o_bank, // Target bank or mode register index
	output logic [AW-1:0] o_row, // Row address of last activate
	output logic [AW-1:0] o_col, // Column address of last read or write
	output logic o_auto_precharge, // Auto-precharge requested
	output logic o_precharge_all, // Precharge addresses all banks
	output logic o_burst_eight, // Full burst of eight
	output logic [15:0] o_mode_register_one, // Stored mode register one
	output logic [2:0] o_mrs_sel, // Last loaded mode register index
	output logic [AW-1:0] o_mrs_opcode, // Last loaded operation code
	output logic [1:0] o_power_state, // Run, precharge or active power-down
	output logic o_inbuf_en, // Command and data input buffers enabled
	output logic o_term_on, // Internal termination applied
	output logic o_termination_strobe_term_on, // Termination on termination strobe pins
	output logic o_beat_valid, // Accepted write data beat pulse
	output logic [15:0] o_beat_data, // Write data beat
	output logic [1:0] o_beat_keep, // Byte lanes kept in beat
	output logic [7:0] o_open_banks // Banks with an open row
);
	// Link-side state, clocked by the true clock rising crossing
	typedef struct packed {
		logic cke;
		logic [2:0] cmd;
		logic [BW-1:0] bank;
		logic [AW-1:0] addr;
		logic tog;
		logic term;
		logic [15:0] mr1;
		logic [7:0] open;
	} dca_lnk_t;
	dca_lnk_t lnk_reg;
	dca_lnk_t lnk_next;
	logic lnk_rst;

	// Pin reset is asynchronous; internal reset also clears link logic
	assign lnk_rst = ~i_reset_n | i_rst; // R22

	// Command decode and bank tracking in the link domain
	always_comb begin
		logic [3:0] code;
		code = {i_cs_n, i_ras_n, i_cas_n, i_we_n}; // R8
		lnk_next = lnk_reg;
		lnk_next.cke = i_clk_en; // R3 R5
		// Termination pin is still sampled during power-down
		lnk_next.term = i_termination_enable; // R6
		if (lnk_reg.cke && i_clk_en && !i_cs_n) begin // R7 R23
			lnk_next.tog = ~lnk_reg.tog;
			lnk_next.bank = i_bank_select; // R15 R16
			lnk_next.addr = i_addr; // R17 R18
			case (code)
				`DCA_CMD_ACT: begin
					lnk_next.cmd = dca_pkg::DCA_C_ACT;
					lnk_next.open[i_bank_select] = 1'b1;
				end
				`DCA_CMD_RD: begin
					lnk_next.cmd = dca_pkg::DCA_C_RD;
					if (i_addr[`DCA_AP_BIT]) lnk_next.open[i_bank_select] = 1'b0; // R20
				end
				`DCA_CMD_WR: begin
					lnk_next.cmd = dca_pkg::DCA_C_WR;
					if (i_addr[`DCA_AP_BIT]) lnk_next.open[i_bank_select] = 1'b0; // R20
				end
				`DCA_CMD_PRE: begin
					lnk_next.cmd = dca_pkg::DCA_C_PRE;
					if (i_addr[`DCA_AP_BIT]) begin // R20
						lnk_next.open = 8'h00;
					end else begin
						lnk_next.open[i_bank_select] = 1'b0;
					end
				end
				`DCA_CMD_MRS: begin
					lnk_next.cmd = dca_pkg::DCA_C_MRS;
					if (i_bank_select[1:0] == 2'h1) lnk_next.mr1 = i_addr[15:0]; // R16 R18
				end
				default: begin
					lnk_next.cmd = dca_pkg::DCA_C_OTHER;
				end
			endcase
		end
	end

	// R1: rising edge of the true clock is the crossing point
	always_ff @(posedge i_diff_clock or posedge lnk_rst) begin
		if (lnk_rst) begin
			lnk_reg <= '{cke: 1'b0, cmd: 3'h0, bank: '0, addr: '0, tog: 1'b0, term: 1'b0,
				mr1: `DCA_MR1_RST, open: 8'h00};
		end else begin
			lnk_reg <= lnk_next; // R1
		end
	end

	// Write mask sampled on both strobe edges: one beat per edge
	logic [15:0] rise_data;
	logic [1:0] rise_mask;
	logic rise_tog;
	logic [15:0] fall_data;
	logic [1:0] fall_mask;
	logic fall_tog;

	always_ff @(posedge i_strobe or posedge lnk_rst) begin
		if (lnk_rst) begin
			rise_data <= 16'h0000;
			rise_mask <= 2'h0;
			rise_tog <= 1'b0;
		end else begin
			rise_data <= i_wdata;
			rise_mask <= {i_upper_byte_mask, i_write_data_mask}; // R12 R14
			rise_tog <= ~rise_tog;
		end
	end

	always_ff @(negedge i_strobe or posedge lnk_rst) begin
		if (lnk_rst) begin
			fall_data <= 16'h0000;
			fall_mask <= 2'h0;
			fall_tog <= 1'b0;
		end else begin
			fall_data <= i_wdata;
			fall_mask <= {i_upper_byte_mask, i_write_data_mask}; // R12 R14
			fall_tog <= ~fall_tog;
		end
	end

	// Crossing: the command toggle is synchronised and the held bundle
	// is read only after it, since the bundle is stable until the next command
	logic [5:0] lvl_sync;
	logic cmd_tog_s;
	logic rise_tog_s;
	logic fall_tog_s;
	logic cke_s;
	logic term_s;
	logic pin_rst_s;

	dca_sync #(.W(6)) u_sync (
		.i_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_d({lnk_reg.tog, rise_tog, fall_tog, lnk_reg.cke, lnk_reg.term, ~i_reset_n}),
		.o_q(lvl_sync)
	);
	assign {cmd_tog_s, rise_tog_s, fall_tog_s, cke_s, term_s, pin_rst_s} = lvl_sync;

	// Core-side state
	typedef struct packed {
		logic ctog;
		logic rtog;
		logic ftog;
		logic cmd_valid;
		logic [2:0] cmd;
		logic [BW-1:0] bank;
		logic [AW-1:0] row;
		logic [AW-1:0] col;
		logic ap;
		logic pall;
		logic bl8;
		logic [15:0] mr1;
		logic [2:0] mrs_sel;
		logic [AW-1:0] opcode;
		logic [1:0] pwr;
		logic inbuf;
		logic term;
		logic termination_strobe_term;
		logic beat_valid;
		logic [15:0] beat_data;
		logic [1:0] keep;
		logic [7:0] open;
		logic in_write;
	} dca_core_t;
	dca_core_t st_reg;
	dca_core_t st_next;

	always_comb begin
		logic odt_on;
		logic [1:0] msk;
		odt_on = 1'b0;
		msk = 2'h0;
		st_next = st_reg;
		st_next.cmd_valid = 1'b0;
		st_next.beat_valid = 1'b0;
		st_next.ctog = cmd_tog_s;
		st_next.rtog = rise_tog_s;
		st_next.ftog = fall_tog_s;
		// New command arrived; bundle has been stable for two core edges
		if (cmd_tog_s != st_reg.ctog) begin
			st_next.cmd_valid = 1'b1;
			st_next.cmd = lnk_reg.cmd; // R8
			st_next.bank = lnk_reg.bank; // R15
			st_next.open = lnk_reg.open;
			st_next.mr1 = lnk_reg.mr1;
			case (lnk_reg.cmd)
				dca_pkg::DCA_C_ACT: begin
					st_next.row = lnk_reg.addr; // R17
				end
				dca_pkg::DCA_C_RD, dca_pkg::DCA_C_WR: begin
					st_next.col = lnk_reg.addr; // R17
					st_next.ap = lnk_reg.addr[`DCA_AP_BIT]; // R20
					st_next.bl8 = lnk_reg.addr[`DCA_BC_BIT]; // R21
					st_next.in_write = (lnk_reg.cmd == dca_pkg::DCA_C_WR);
				end
				dca_pkg::DCA_C_PRE: begin
					st_next.pall = lnk_reg.addr[`DCA_AP_BIT]; // R20
				end
				dca_pkg::DCA_C_MRS: begin
					st_next.mrs_sel = {1'b0, lnk_reg.bank[1:0]}; // R16
					st_next.opcode = lnk_reg.addr; // R18
				end
				default: begin
					st_next.in_write = st_reg.in_write;
				end
			endcase
		end
		// Pin reset clears the core copies of open rows, mode register one and write state; toggles dropped by it raise no pulse
		if (pin_rst_s) begin // R22
			st_next.cmd_valid = 1'b0;
			st_next.open = 8'h00;
			st_next.mr1 = `DCA_MR1_RST;
			st_next.in_write = 1'b0;
		end
		// Power state from registered clock enable; next open set keeps it in step
		if (!cke_s) begin // R4 R5
			st_next.pwr = (|st_next.open) ? dca_pkg::DCA_P_ACT_PD : dca_pkg::DCA_P_PRE_PD;
		end else begin
			st_next.pwr = dca_pkg::DCA_P_RUN;
		end
		st_next.inbuf = cke_s; // R3 R6
		// Termination honoured only when mode register one enables it
		odt_on = (st_reg.mr1[`DCA_RTT_B0] | st_reg.mr1[`DCA_RTT_B1] | st_reg.mr1[`DCA_RTT_B2]);
		st_next.term = term_s & odt_on; // R9 R10
		st_next.termination_strobe_term = term_s & odt_on & ~X16 & st_reg.mr1[`DCA_TERMINATION_STROBE_BIT]; // R9 R13
		// Beats: mask pin is a mask only when the termination strobe is off
		if (rise_tog_s != st_reg.rtog || fall_tog_s != st_reg.ftog) begin
			msk = (rise_tog_s != st_reg.rtog) ? rise_mask : fall_mask; // R12
			st_next.beat_data = (rise_tog_s != st_reg.rtog) ? rise_data : fall_data;
			if (!X16) begin
				msk[1] = 1'b1; // Narrow part has no upper lane, never kept
				if (st_reg.mr1[`DCA_TERMINATION_STROBE_BIT]) msk[0] = 1'b0; // R13
			end
			st_next.keep = ~msk; // R11 R14
			st_next.beat_valid = st_reg.in_write && st_reg.inbuf && !pin_rst_s && (msk != 2'h3); // R11
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// All outputs straight from core flip-flops; strobe outputs reference
	// the differential crossings outside this stage (R2)
	assign o_cmd_valid = st_reg.cmd_valid;
	assign o_cmd = st_reg.cmd;
	assign o_bank = st_reg.bank;
	assign o_row = st_reg.row;
	assign o_col = st_reg.col;
	assign o_auto_precharge = st_reg.ap;
	assign o_precharge_all = st_reg.pall;
	assign o_burst_eight = st_reg.bl8;
	assign o_mode_register_one = st_reg.mr1;
	assign o_mrs_sel = st_reg.mrs_sel;
	assign o_mrs_opcode = st_reg.opcode;
	assign o_power_state = st_reg.pwr;
	assign o_inbuf_en = st_reg.inbuf;
	assign o_term_on = st_reg.term;
	assign o_termination_strobe_term_on = st_reg.termination_strobe_term;
	assign o_beat_valid = st_reg.beat_valid;
	assign o_beat_data = st_reg.beat_data;
	assign o_beat_keep = st_reg.keep;
	assign o_open_banks = st_reg.open;
endmodule : dca_cmd_addr_in
`default_nettype wire

// ---- tb/dca_ctrl_model.sv ----
// Controller-side model driving the command, address and clock-enable pins
`timescale 1ns/1ps
`default_nettype none
module dca_ctrl_model #(
	parameter bit X16 = 1'b0 // Device wired as x16
) (
	output logic o_clk_en, // Clock enable pin
	output logic [3:0] o_code, // Chip select, row, column and write strobes
	output logic [2:0] o_bank_select, // Bank select pins
	output logic [15:0] o_addr, // Address pins
	input wire logic i_diff_clock // Link clock, free running
);
	bit busy = 1'b0;
	initial begin
		o_clk_en = 1'b1;
		o_code = 4'hf;
		o_bank_select = 3'h0;
		o_addr = {X16, 15'h0000};
	end
	// Idle fields change every cycle so a stale value never passes for a command field
	always @(posedge i_diff_clock) begin
		#1;
		if (!busy) begin
			o_bank_select = ~o_bank_select;
			o_addr = ~o_addr | {X16, 15'h0000};
		end
	end
	// One command, held across exactly one sampling crossing
	task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
		@(posedge i_diff_clock);
		busy = 1'b1;
		#1;
		o_code = c;
		o_bank_select = b;
		o_addr = a | {X16, 15'h0000};
		@(posedge i_diff_clock);
		#1;
		o_code = 4'hf;
		busy = 1'b0;
	endtask : issue
	// Clock enable moves just after a crossing, never between them
	task automatic set_cke(input logic v);
		@(posedge i_diff_clock);
		#1;
		o_clk_en = v;
	endtask : set_cke
endmodule : dca_ctrl_model
`default_nettype wire

// ---- tb/dca_sva.sv ----
// Property checker for the command and address input stage
`timescale 1ns/1ps
`default_nettype none
module dca_sva #(
	parameter bit X16 = 1'b0
) (
	input wire logic i_sys_clk, // Core clock
	input wire logic i_rst, // Core reset
	input wire logic i_reset_n, // Device reset pin
	input wire logic o_cmd_valid, // Command pulse
	input wire logic [2:0] o_cmd, // Command kind
	input wire logic [2:0] o_bank, // Bank or mode register index
	input wire logic o_precharge_all, // Precharge of all banks
	input wire logic [15:0] o_mode_register_one, // Mode register one
	input wire logic [2:0] o_mrs_sel, // Loaded index
	input wire logic o_inbuf_en, // Input buffers on
	input wire logic [1:0] o_power_state, // Power state
	input wire logic o_term_on, // Termination
	input wire logic o_termination_strobe_term_on, // Strobe termination
	input wire logic o_beat_valid, // Beat pulse
	input wire logic [1:0] o_beat_keep, // Lanes kept
	input wire logic [7:0] o_open_banks // Open rows
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	sequence s_mrs;
		o_cmd_valid && o_cmd == dca_pkg::DCA_C_MRS;
	endsequence
	sequence s_term_off;
		!(o_mode_register_one[2] || o_mode_register_one[6] || o_mode_register_one[9]);
	endsequence
	chk_cmd_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
		else $error("command pulse too long");
	chk_mrs_index: assert property (s_mrs |-> ##[0:1] o_mrs_sel == o_bank)
		else $error("wrong mode register index");
	chk_term_gate: assert property (s_term_off [*3] |-> !o_term_on)
		else $error("termination on while disabled");
	chk_termination_strobe_gate: assert property (!o_mode_register_one[11] [*3] |-> !o_termination_strobe_term_on)
		else $error("strobe termination without enable");
	chk_x8_lane: assert property (o_beat_valid && !X16 |-> o_beat_keep == 2'h1)
		else $error("wrong lanes on narrow part");
	chk_masked_drop: assert property (o_beat_valid |-> o_beat_keep != 2'h0)
		else $error("fully masked beat passed");
	chk_pd_quiet: assert property (!o_inbuf_en [*4] |-> !o_cmd_valid)
		else $error("command with buffers off");
	chk_pd_kind: assert property (o_power_state != 2'h0 |->
		(o_power_state == 2'h2) == (o_open_banks != 8'h00))
		else $error("wrong power-down kind");
	chk_pre_all: assert property (o_cmd_valid && o_cmd == dca_pkg::DCA_C_PRE && o_precharge_all
		|-> ##[0:2] o_open_banks == 8'h00)
		else $error("banks left open");
	chk_act_open: assert property (o_cmd_valid && o_cmd == dca_pkg::DCA_C_ACT
		|-> ##[0:2] o_open_banks[o_bank])
		else $error("activated bank not open");
	chk_rst_clear: assert property (!i_reset_n [*5] |->
		o_open_banks == 8'h00 && o_mode_register_one == 16'h0000)
		else $error("state kept through reset");
endmodule : dca_sva
bind dca_cmd_addr_in dca_sva #(.X16(X16)) i_sva (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
	.i_reset_n(i_reset_n), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_bank(o_bank),
	.o_precharge_all(o_precharge_all), .o_mode_register_one(o_mode_register_one),
	.o_mrs_sel(o_mrs_sel), .o_inbuf_en(o_inbuf_en), .o_power_state(o_power_state),
	.o_term_on(o_term_on), .o_termination_strobe_term_on(o_termination_strobe_term_on), .o_beat_valid(o_beat_valid),
	.o_beat_keep(o_beat_keep), .o_open_banks(o_open_banks));
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the command and address input stage
`timescale 1ns/1ps
`default_nettype none
`include "dca_map.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	$display("MISMATCH %s exp %h got %h", n, e, g); err_total++; end end
`define WAITEQ(n, e, g) begin for (int k = 0; k < 60 && (g) !== (e); k++) \
	tick(); `CHK(n, e, g) if ((g) !== (e)) close_out(); end
module testbench;
	typedef struct packed {logic [2:0] k; logic [2:0] b; logic [15:0] a;} dca_exp_t;
	logic i_sys_clk = 1'b0, i_rst = 1'b1, i_reset_n = 1'b0, lclk = 1'b0, termination_enable = 1'b0;
	logic strobe = 1'b0, wmask = 1'b0, cke, cv, ap, pa, b8, trm, tdq, bv, ib;
	logic [15:0] wdata = 16'h0000, ad, row, col, mr1, mop, bd, r;
	logic [3:0] code;
	logic [2:0] ba, cmd, bank, msel;
	logic [1:0] ps, keep;
	logic [7:0] ob;
	dca_exp_t cq[$];
	logic [15:0] bq[$];
	int err_total = 0, cmp_count = 0;
	always #50 i_sys_clk = ~i_sys_clk;
	always #3 lclk = ~lclk;
	dca_ctrl_model i_ctrl (.i_diff_clock(lclk), .o_clk_en(cke), .o_code(code),
		.o_bank_select(ba), .o_addr(ad));
	dca_cmd_addr_in i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_diff_clock(lclk),
		.i_reset_n(i_reset_n), .i_clk_en(cke), .i_cs_n(code[3]), .i_ras_n(code[2]),
		.i_cas_n(code[1]), .i_we_n(code[0]), .i_bank_select(ba), .i_addr(ad),
		.i_termination_enable(termination_enable), .i_strobe(strobe), .i_wdata(wdata),
		.i_write_data_mask(wmask), .i_upper_byte_mask(1'b0), .o_cmd_valid(cv), .o_cmd(cmd),
		.o_bank(bank), .o_row(row), .o_col(col), .o_auto_precharge(ap), .o_precharge_all(pa),
		.o_burst_eight(b8), .o_mode_register_one(mr1), .o_mrs_sel(msel), .o_mrs_opcode(mop),
		.o_power_state(ps), .o_inbuf_en(ib), .o_term_on(trm), .o_termination_strobe_term_on(tdq),
		.o_beat_valid(bv), .o_beat_data(bd), .o_beat_keep(keep), .o_open_banks(ob));
	task automatic close_out();
		if (cq.size() + bq.size() != 0) err_total++;
		if (err_total == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic tick();
		@(posedge i_sys_clk);
		#1;
	endtask : tick
	// Note the expected decode, then let the controller model issue it
	task automatic note(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
		dca_exp_t e;
		e = {3'h6, b, a};
		case (c)
			`DCA_CMD_ACT: e.k = 3'h1;
			`DCA_CMD_RD: e.k = 3'h2;
			`DCA_CMD_WR: e.k = 3'h3;
			`DCA_CMD_PRE: e.k = 3'h4;
			`DCA_CMD_MRS: e.k = 3'h5;
			default: e.k = 3'h6;
		endcase
		if (!c[3] && cke) cq.push_back(e);
		i_ctrl.issue(c, b, a);
	endtask : note
	// Spacing keeps commands slower than the core-side crossing can carry
	task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
		note(c, b, a);
		`WAITEQ("drain", 0, cq.size())
		repeat (5) tick();
	endtask : send
	// Oldest note is compared whenever a result pulse appears
	always @(posedge i_sys_clk) begin
		dca_exp_t e;
		logic [15:0] d;
		#2;
		if (cv === 1'b1) begin
			e = (cq.size() > 0) ? cq.pop_front() : '1;
			`CHK("cmd", e.k, cmd)
			`CHK("bank", e.b, bank)
			if (e.k == 3'h1) `CHK("row", e.a, row)
			if (e.k == 3'h2 || e.k == 3'h3) begin
				`CHK("col", e.a[5:0], col[5:0])
				`CHK("autopre", e.a[10], ap)
				`CHK("burst", e.a[12], b8)
			end
			if (e.k == 3'h4) `CHK("pall", e.a[10], pa)
			if (e.k == 3'h5) `CHK("opcode", e.a, mop)
			if (e.k == 3'h5) `CHK("msel", e.b, msel)
		end
		if (bv === 1'b1) begin
			d = (bq.size() > 0) ? bq.pop_front() : ~bd;
			`CHK("beat", d[7:0], bd[7:0])
			`CHK("keep", 2'h1, keep)
		end
	end
	// Main sequence
	initial begin
		void'($urandom(32'hcdbf));
		repeat (3) tick();
		i_rst = 1'b0;
		i_reset_n = 1'b1;
		repeat (4) tick();
		for (int i = 0; i < 4; i++) send(`DCA_CMD_MRS, 3'(i), (i == 1) ? 16'h0804 : 16'($urandom));
		`WAITEQ("mr1", 16'h0804, mr1)
		termination_enable = 1'b1;
		`WAITEQ("term", 1'b1, trm)
		`WAITEQ("termination_strobe", 1'b1, tdq)
		send(`DCA_CMD_MRS, 3'h1, 16'h0000);
		`WAITEQ("term off", 1'b0, trm)
		r = 16'($urandom);
		send(`DCA_CMD_ACT, 3'h5, r);
		`WAITEQ("open", 8'h20, ob)
		send(`DCA_CMD_ACT | 4'h8, 3'h2, r);
		`CHK("deselect", 8'h20, ob)
		// Beats count only once the write has landed; edges 0 and 1 kept, 2 and 3 masked
		send(`DCA_CMD_WR, 3'h5, 16'h1000 | (r & 16'h003f));
		for (int j = 0; j < 4; j++) begin
			wdata = 16'($urandom);
			wmask = j[1];
			if (!wmask) bq.push_back(wdata);
			strobe = ~strobe;
			repeat (5) tick();
		end
		wmask = 1'b0;
		`WAITEQ("beats", 0, bq.size())
		send(`DCA_CMD_RD, 3'h5, 16'h0400 | (r & 16'h003f));
		`WAITEQ("ap close", 8'h00, ob)
		send(`DCA_CMD_ACT, 3'h5, r);
		send(`DCA_CMD_REF, 3'h0, r);
		send(`DCA_CMD_ZQ, 3'h0, r);
		i_ctrl.set_cke(1'b0);
		`WAITEQ("act pd", 2'h2, ps)
		`WAITEQ("inbuf", 1'b0, ib)
		send(`DCA_CMD_PRE, 3'h5, 16'h0400);
		`CHK("pd hold", 8'h20, ob)
		i_ctrl.set_cke(1'b1);
		`WAITEQ("run", 2'h0, ps)
		repeat (8) tick();
		send(`DCA_CMD_PRE, 3'h5, 16'h0400);
		`WAITEQ("pre all", 8'h00, ob)
		i_ctrl.set_cke(1'b0);
		`WAITEQ("pre pd", 2'h1, ps)
		i_ctrl.set_cke(1'b1);
		`WAITEQ("run2", 2'h0, ps)
		repeat (8) tick();
		send(`DCA_CMD_ACT, 3'h0, r);
		i_reset_n = 1'b0;
		repeat (6) tick();
		`CHK("reset", 8'h00, ob)
		i_reset_n = 1'b1;
		repeat (8) tick();
		send(`DCA_CMD_ACT, 3'h7, ~r);
		`WAITEQ("open2", 8'h80, ob)
		close_out();
	end
endmodule : testbench
`default_nettype wire
